// >>> src/adc_conversion_host_interface.sv
`timescale 1ns/100ps
`default_nettype none
module adc_conversion_host_interface
    import adc_host_pkg::*;
#(
    parameter int DEPTH = adc_host_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Conversion control
    input wire logic convert_start_n,
    input wire logic adc_reset,
    input wire logic full_powerdown,
    input wire logic low_power_mode,
    output logic busy,
    output logic core_powered,
    // Reference configuration
    input wire logic ref_powerdown,
    input wire logic refbuf_powerdown,
    output logic ref_enable,
    output logic refbuf_enable,
    output adc_host_pkg::ref_mode_t ref_mode,
    // Sampled converter result
    input wire logic [adc_host_pkg::RESULT_W-1:0] sar_result,
    // Host interface
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic serial_parallel_select,
    input wire logic output_coding_select,
    input wire logic byte_order_select,
    input wire logic serial_clk,
    output logic [adc_host_pkg::RESULT_W-1:0] data_out,
    output logic [adc_host_pkg::RESULT_W-1:0] data_oe,
    output logic serial_data_out,
    output logic serial_data_oe
);
    import adc_host_pkg::*;

    // ------------------------------------------------------------
    // Reference control
    // ------------------------------------------------------------
    // Both powered down: reference must come from outside
    wire ref_on = !ref_powerdown;
    wire buf_on = !refbuf_powerdown;
    ref_mode_t ref_mode_next;
    assign ref_mode_next = !ref_powerdown ? REF_INTERNAL :
        (refbuf_powerdown ? REF_EXT_DIRECT : REF_EXT_BUFFERED);

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            ref_enable <= 1'b0;
            refbuf_enable <= 1'b0;
            ref_mode <= REF_INTERNAL;
        end
        else
        begin
            ref_enable <= ref_on;
            refbuf_enable <= buf_on;
            ref_mode <= ref_mode_next;
        end
    end

    // ------------------------------------------------------------
    // Conversion sequencer
    // ------------------------------------------------------------
    conv_state_t state_reg;
    conv_state_t state_next;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic cnv_prev_reg;
    logic arst_prev_reg;
    logic [RESULT_W-1:0] result_reg;
    // Edges of the sampled control pins
    wire cnv_fall = cnv_prev_reg && !convert_start_n;
    wire arst_fall = !adc_reset && arst_prev_reg;
    wire conv_done = (state_reg == ST_CONV) && (cnt_reg == '0);
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [RESULT_W-1:0] fifo_out_data;

    // Coding conversion of the raw two's complement result
    function automatic logic [RESULT_W-1:0] code(input logic [RESULT_W-1:0] raw,
                                                 input logic straight);
        code = straight ? (raw ^ SIGN_MASK) : raw;
    endfunction

    // Converting or initialising
    function automatic logic is_active(input conv_state_t st);
        is_active = (st != ST_IDLE);
    endfunction

    always_comb
    begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        if (adc_reset)
        begin
            state_next = ST_IDLE;
            cnt_next = '0;
        end
        else if (arst_fall)
        begin
            state_next = ST_INIT;
            cnt_next = CNT_W'(INIT_CYCLES - 1);
        end
        else
        begin
            unique case (state_reg)
                ST_IDLE:
                begin
                    if (cnv_fall)
                    begin
                        state_next = ST_CONV;
                        cnt_next = CNT_W'(CONV_CYCLES - 1);
                    end
                end
                ST_CONV:
                begin
                    if (cnt_reg == '0)
                    begin
                        state_next = ST_IDLE;
                    end
                    else
                    begin
                        cnt_next = cnt_reg - CNT_W'(1);
                    end
                end
                ST_INIT:
                begin
                    if (cnt_reg == '0)
                    begin
                        state_next = ST_IDLE;
                    end
                    else
                    begin
                        cnt_next = cnt_reg - CNT_W'(1);
                    end
                end
                default:
                begin
                    state_next = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state_reg <= ST_IDLE;
            cnt_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
        end
    end

    // Start pin history idles high, so leaving reset makes no false edge
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            cnv_prev_reg <= 1'b1;
            arst_prev_reg <= 1'b0;
        end
        else
        begin
            cnv_prev_reg <= convert_start_n;
            arst_prev_reg <= adc_reset;
        end
    end

    // Busy is high in conversion and initialisation
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            busy <= 1'b0;
        end
        else
        begin
            busy <= is_active(state_next);
        end
    end

    // ------------------------------------------------------------
    // Core power control
    // ------------------------------------------------------------
    // Power-down waits for the idle state, so it cannot cut a conversion
    wire sleep_request = low_power_mode || full_powerdown;
    wire core_awake_next = is_active(state_next) || !sleep_request;

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            core_powered <= 1'b1;
        end
        else
        begin
            core_powered <= core_awake_next;
        end
    end

    // ------------------------------------------------------------
    // Result buffering
    // ------------------------------------------------------------
    result_fifo #(
        .WIDTH(RESULT_W),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clk(clk),
        .reset(reset || adc_reset),
        .in_valid(conv_done),
        .in_ready(fifo_in_ready),
        .in_data(sar_result),
        .out_valid(fifo_out_valid),
        .out_ready(1'b1),
        .out_data(fifo_out_data)
    );

    // Latest result, cleared by reset release
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            result_reg <= DATA_RESET;
        end
        else if (adc_reset || arst_fall)
        begin
            result_reg <= DATA_RESET;
        end
        else
        begin
            if (fifo_out_valid)
            begin
                result_reg <= fifo_out_data;
            end
        end
    end

    // ------------------------------------------------------------
    // Parallel and serial output
    // ------------------------------------------------------------
    localparam int LANES = RESULT_W / BYTE_W;
    wire [RESULT_W-1:0] coded = code(result_reg, output_coding_select);
    wire [RESULT_W-1:0] fresh_coded = code(fifo_out_data, output_coding_select);
    wire [RESULT_W-1:0] par_word;
    wire read_en = !cs_n && !rd_n && !adc_reset;
    wire par_drive = read_en && !serial_parallel_select;
    wire ser_drive = read_en && serial_parallel_select;

    // Byte lanes mirror end for end when the order select is high
    genvar lane;
    generate
        for (lane = 0; lane < LANES; lane = lane + 1)
        begin : g_lane
            assign par_word[lane*BYTE_W +: BYTE_W] = byte_order_select ?
                coded[(LANES-1-lane)*BYTE_W +: BYTE_W] : coded[lane*BYTE_W +: BYTE_W];
        end
    endgenerate

    logic sclk_prev_reg;
    logic [SER_CNT_W-1:0] bit_cnt_reg;
    logic [RESULT_W-1:0] shift_reg;
    wire sclk_fall = !serial_clk && sclk_prev_reg;
    wire shift_done = (bit_cnt_reg == SER_CNT_W'(RESULT_W));
    // Reload while no serial read runs, and on each new result
    wire ser_load = !ser_drive || fifo_out_valid;
    wire ser_shift = sclk_fall && !shift_done;
    wire [RESULT_W-1:0] load_word = fifo_out_valid ? fresh_coded : coded;

    // Bits shift only on the falling clock edge, after the rising one
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            sclk_prev_reg <= 1'b0;
            bit_cnt_reg <= '0;
            shift_reg <= DATA_RESET;
        end
        else
        begin
            sclk_prev_reg <= serial_clk;
            if (ser_load)
            begin
                shift_reg <= load_word;
                bit_cnt_reg <= '0;
            end
            else if (ser_shift)
            begin
                shift_reg <= {shift_reg[RESULT_W-2:0], 1'b0};
                bit_cnt_reg <= bit_cnt_reg + SER_CNT_W'(1);
            end
        end
    end

    // ------------------------------------------------------------
    // Pin registers
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            data_out <= DATA_RESET;
            data_oe <= '0;
            serial_data_out <= 1'b0;
            serial_data_oe <= 1'b0;
        end
        else
        begin
            data_out <= par_word;
            data_oe <= {RESULT_W{par_drive}};
            serial_data_out <= shift_reg[RESULT_W-1];
            serial_data_oe <= ser_drive;
        end
    end
endmodule // adc_conversion_host_interface
`default_nettype wire

// >>> include/adc_host_pkg.sv
`default_nettype none
package adc_host_pkg;
    localparam int RESULT_W = 16;
    localparam int BYTE_W = 8;
    // Conversion timing in ns, converted to 125 MHz cycles
    localparam int CLK_PERIOD_NS = 8;
    localparam int CONV_TIME_NS = 200;
    localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int INIT_TIME_NS = 96;
    localparam int INIT_CYCLES = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 8;
    localparam int SER_CNT_W = 5;
    localparam int FIFO_DEPTH = 16;
    localparam logic [RESULT_W-1:0] DATA_RESET = 16'h0000;
    localparam logic [RESULT_W-1:0] SIGN_MASK = 16'h8000;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CONV = 2'b01,
        ST_INIT = 2'b10
    } conv_state_t;
    typedef enum logic [1:0] {
        REF_INTERNAL = 2'b00,
        REF_EXT_BUFFERED = 2'b01,
        REF_EXT_DIRECT = 2'b11
    } ref_mode_t;
endpackage
`default_nettype wire

// >>> src/result_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module result_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    assign in_ready = (count_reg != (AW+1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign out_data = mem[rd_ptr_reg];
    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem[wr_ptr_reg] <= in_data;
        end
    end
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_reg <= wr_ptr_reg + AW'(1);
            end
            if (pop)
            begin
                rd_ptr_reg <= rd_ptr_reg + AW'(1);
            end
            count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // result_fifo
`default_nettype wire

// >>> sim/adc_host_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module adc_host_monitor
    import adc_host_pkg::*;
(
    // Control
    input wire logic clk,
    input wire logic reset,
    input wire logic convert_start_n,
    input wire logic adc_reset,
    input wire logic busy,
    input wire logic ref_powerdown,
    input wire logic refbuf_powerdown,
    input wire logic ref_enable,
    input wire logic refbuf_enable,
    // Host side
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic serial_parallel_select,
    input wire logic serial_clk,
    input wire logic [adc_host_pkg::RESULT_W-1:0] data_oe,
    input wire logic serial_data_out,
    input wire logic serial_data_oe
);
    logic [7:0] span_reg;
    logic [7:0] span_next;
    assign span_next = busy ? span_reg + 8'h01 : 8'h00;
    always_ff @(posedge clk)
    begin
        span_reg <= reset ? 8'h00 : span_next;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    sequence conv_req;
        $fell(convert_start_n) && !busy && !adc_reset && !$past(adc_reset);
    endsequence
    sequence host_read;
        !cs_n && !rd_n && !adc_reset && !$past(adc_reset);
    endsequence
    a_start_sets_busy: assert property (conv_req |=> busy)
        else $error("no busy after start");
    a_busy_span: assert property ($fell(busy) && !adc_reset && !$past(adc_reset) |->
        span_reg == CONV_CYCLES || span_reg == INIT_CYCLES) else $error("busy span");
    a_idle_tristate: assert property (cs_n || rd_n |=> data_oe == 0 && !serial_data_oe)
        else $error("bus driven while deselected");
    a_abort_tristate: assert property (adc_reset ##1 adc_reset |-> !busy && data_oe == 0)
        else $error("abort left bus or busy");
    a_par_drive: assert property (host_read ##0 !serial_parallel_select |=> &data_oe)
        else $error("parallel bus not driven");
    a_ser_drive: assert property (host_read ##0 serial_parallel_select |=> serial_data_oe)
        else $error("serial output not driven");
    a_ser_stable: assert property ($changed(serial_clk) && serial_data_oe && $past(serial_data_oe)
        |-> $stable(serial_data_out)) else $error("serial bit moved at a clock edge");
    a_ref_follow: assert property (!$past(reset) |-> ref_enable != $past(ref_powerdown)
        && refbuf_enable != $past(refbuf_powerdown)) else $error("reference enables");
endmodule // adc_host_monitor
`default_nettype wire

// >>> sim/host_serial_reader.sv
`timescale 1ns/100ps
`default_nettype none
module host_serial_reader (
    // Handshake
    input wire logic clk,
    input wire logic start,
    output logic done,
    // Serial line
    input wire logic serial_data_out,
    output logic serial_clk,
    output logic [15:0] word
);
    logic [7:0] step_reg = 8'h00;
    initial serial_clk = 1'b0;
    initial done = 1'b0;
    // Clock idles low; each level held 4 cycles, 16 pulses
    always @(posedge clk)
    begin
        if (step_reg == 8'h00)
            step_reg <= {7'h00, start};
        else
            step_reg <= (step_reg == 8'h80) ? 8'h00 : step_reg + 8'h01;
        serial_clk <= step_reg[2];
        done <= start ? 1'b0 : (done | (step_reg == 8'h80));
        if (step_reg[2:0] == 3'h4)
            word <= {word[14:0], serial_data_out};
    end
endmodule // host_serial_reader
`default_nettype wire

// >>> sim/adc_conversion_host_interface_bench.sv
`timescale 1ns/100ps
`default_nettype none
module adc_conversion_host_interface_bench;
    import adc_host_pkg::*;
    logic clk = 1'b0, reset = 1'b1, convert_start_n = 1'b1, adc_reset = 1'b0;
    logic full_powerdown = 1'b0, low_power_mode = 1'b0, ref_powerdown = 1'b0;
    logic refbuf_powerdown = 1'b0, cs_n = 1'b1, rd_n = 1'b1, serial_parallel_select = 1'b0;
    logic output_coding_select = 1'b0, byte_order_select = 1'b0, rd_start = 1'b0;
    logic busy, core_powered, ref_enable, refbuf_enable, serial_data_out, serial_data_oe;
    logic serial_clk, rd_done;
    logic [15:0] sar_result = 16'h0000, data_out, data_oe, rd_word, raw, exp;
    ref_mode_t ref_mode;
    int n_errors = 0, compares = 0, seed = 32'h513a, len = 0, span = 0;
    always #4 clk = ~clk;
    adc_conversion_host_interface u_adc_conversion_host_interface (.clk, .reset,
        .convert_start_n, .adc_reset, .full_powerdown, .low_power_mode, .busy,
        .core_powered, .ref_powerdown, .refbuf_powerdown, .ref_enable, .refbuf_enable,
        .ref_mode, .sar_result, .cs_n, .rd_n, .serial_parallel_select,
        .output_coding_select, .byte_order_select, .serial_clk, .data_out, .data_oe,
        .serial_data_out, .serial_data_oe);
    host_serial_reader u_host_serial_reader (.clk, .start(rd_start), .done(rd_done),
        .serial_data_out, .serial_clk, .word(rd_word));
    // Length of the last busy pulse
    always @(negedge clk)
    begin
        span = (busy !== 1'b1 && len != 0) ? len : span;
        len = (busy === 1'b1) ? len + 1 : 0;
    end
    // Reference mode the power-down pins call for
    function automatic ref_mode_t want_ref(input logic pd_ref, input logic pd_buf);
        if (pd_ref && pd_buf)
            return REF_EXT_DIRECT;
        if (pd_ref)
            return REF_EXT_BUFFERED;
        return REF_INTERNAL;
    endfunction
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] want);
        compares++;
        if (seen !== want)
        begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, want, seen);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic settle();
        repeat (3) @(posedge clk);
        for (int i = 0; i < 100 && busy !== 1'b0; i++) @(posedge clk);
        repeat (2) @(negedge clk);
    endtask
    // Second start and power-down land mid-conversion when twice is set
    task automatic convert(input logic twice);
        @(posedge clk) convert_start_n <= 1'b0;
        cs_n <= 1'($random(seed));
        rd_n <= 1'($random(seed));
        serial_parallel_select <= 1'b0;
        repeat (2) @(posedge clk);
        convert_start_n <= 1'b1;
        repeat (6) @(posedge clk);
        convert_start_n <= !twice;
        full_powerdown <= twice;
        repeat (2) @(posedge clk);
        convert_start_n <= 1'b1;
        @(negedge clk) check("core awake", 16'(core_powered), 16'h0001);
        settle();
        check("busy span", 16'(span), 16'(CONV_CYCLES));
        @(posedge clk) cs_n <= 1'b1;
        rd_n <= 1'b1;
        full_powerdown <= 1'b0;
    endtask
    task automatic read(input logic ser, input logic [15:0] want);
        @(posedge clk) serial_parallel_select <= ser;
        cs_n <= 1'b0;
        rd_n <= 1'b0;
        rd_start <= ser;
        repeat (3) @(posedge clk) rd_start <= 1'b0;
        for (int i = 0; i < 200 && ser && rd_done !== 1'b1; i++) @(posedge clk);
        @(negedge clk) check("result", ser ? rd_word : data_out, want);
        @(posedge clk) cs_n <= 1'b1;
        rd_n <= 1'b1;
    endtask
    initial
    begin
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk) adc_reset <= 1'b1;
        repeat (4) @(posedge clk);
        adc_reset <= 1'b0;
        settle();
        check("init span", 16'(span), 16'(INIT_CYCLES));
        read(1'b0, DATA_RESET);
        for (int k = 0; k < 8; k++)
        begin
            raw = (k == 0) ? 16'h8000 : (k == 1) ? 16'h7fff : 16'($random(seed));
            @(posedge clk) sar_result <= raw;
            output_coding_select <= k[0];
            byte_order_select <= k[1];
            {ref_powerdown, refbuf_powerdown, low_power_mode} <= 3'(k);
            convert(k[2]);
            exp = k[0] ? raw ^ SIGN_MASK : raw;
            read(1'b0, k[1] ? {exp[7:0], exp[15:8]} : exp);
            read(1'b1, exp);
            check("ref mode", 16'(ref_mode), 16'(want_ref(k[2], k[1])));
            check("ref enables", 16'({ref_enable, refbuf_enable}), 16'({!k[2], !k[1]}));
            check("core power", 16'(core_powered), 16'(!k[0]));
        end
        @(posedge clk) convert_start_n <= 1'b0;
        cs_n <= 1'b0;
        rd_n <= 1'b0;
        serial_parallel_select <= 1'b0;
        repeat (6) @(posedge clk);
        convert_start_n <= 1'b1;
        adc_reset <= 1'b1;
        repeat (3) @(negedge clk);
        check("aborted busy", 16'(busy), 16'h0000);
        check("aborted bus", data_oe, 16'h0000);
        @(posedge clk) adc_reset <= 1'b0;
        cs_n <= 1'b1;
        rd_n <= 1'b1;
        output_coding_select <= 1'b0;
        settle();
        check("init span", 16'(span), 16'(INIT_CYCLES));
        read(1'b0, DATA_RESET);
        stop_test();
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        n_errors++;
        stop_test();
    end
endmodule // adc_conversion_host_interface_bench
bind adc_conversion_host_interface adc_host_monitor u_adc_host_monitor (.clk, .reset,
    .convert_start_n, .adc_reset, .busy, .ref_powerdown, .refbuf_powerdown, .ref_enable,
    .refbuf_enable, .cs_n, .rd_n, .serial_parallel_select, .serial_clk, .data_oe,
    .serial_data_out, .serial_data_oe);
`default_nettype wire
